/* File: core/meter_pkg.sv */
package meter_pkg;

    typedef logic [23:0] word_t;

    // register byte offsets on the AXI4-Lite slave
    localparam logic [5:0] OFF_CONFIG = 6'h00;
    localparam logic [5:0] OFF_STATUS = 6'h04;
    localparam logic [5:0] OFF_MASK = 6'h08;
    localparam logic [5:0] OFF_CYCLE = 6'h0C;
    localparam logic [5:0] OFF_SAG_THR = 6'h10;
    localparam logic [5:0] OFF_SAG_WIN = 6'h14;
    localparam logic [5:0] OFF_NL_INT = 6'h18;
    localparam logic [5:0] OFF_NL_MIN = 6'h1C;
    localparam logic [5:0] OFF_TSCALE = 6'h20;
    localparam logic [5:0] OFF_TEMP_ZERO_OFFSET = 6'h24;
    localparam logic [5:0] OFF_TEMP = 6'h28;
    localparam logic [5:0] OFF_CMD = 6'h2C;
    localparam logic [5:0] OFF_STATE = 6'h30;

    // status bit positions
    localparam int unsigned STAT_READY = 0;
    localparam int unsigned STAT_TEMP = 1;
    localparam int unsigned STAT_SAG = 2;

    // command bytes
    localparam logic [7:0] CMD_SOFT_RESET = 8'h80;
    localparam logic [7:0] CMD_STANDBY = 8'h88;
    localparam logic [7:0] CMD_SLEEP = 8'h90;
    localparam logic [7:0] CMD_POWER_UP = 8'hA0;
    localparam logic [7:0] CMD_START_SINGLE = 8'hE0;
    localparam logic [7:0] CMD_START_CONT = 8'hE8;
    localparam logic [7:0] CMD_START_CONT_APF = 8'hEC;

    // timing: crystal settle, reset pin width, sample and temperature rates
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned RST_PIN_MIN_NS = 50;
    localparam int unsigned RST_PIN_MIN_CYCLES = (RST_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETTLE_LAST = 4'h7; // eight crystal periods
    localparam logic [9:0] SAMPLE_DIV_LAST = 10'h3FF; // 1024 divided clocks per sample
    localparam logic [11:0] TEMP_UPDATE_LAST = 12'h8BF; // 2240 samples per result

    typedef enum logic [2:0] {
        PS_RESET = 3'b000,
        PS_SETTLE = 3'b001,
        PS_ACTIVE = 3'b010,
        PS_STANDBY = 3'b011,
        PS_SLEEP = 3'b100
    } pwr_state_e;

    // configuration register layout, divisor in the low nibble
    typedef struct packed {
        logic [17:0] rsvd;
        logic irq_polarity_invert;
        logic irq_pulse_select;
        logic [3:0] divisor;
    } cfg_s;

    typedef struct packed {
        word_t volt;
        word_t energy;
        word_t temp_raw;
    } sample_s;

    typedef struct packed {
        pwr_state_e state;
        logic stby;
        logic slp;
        logic [3:0] settle_cnt;
        logic [3:0] divided_core_clk_cnt;
        logic [9:0] samp_cnt;
        logic samp_stb;
        cfg_s cfg;
        logic [2:0] status;
        logic [2:0] mask;
        word_t cycle, sag_thr, sag_win, nl_int, nl_min, tscale, temp_zero_offset, temp;
        logic conv_run;
        logic conv_cont;
        word_t conv_cnt, sag_cnt, sag_low, nl_cnt;
        logic [39:0] nl_acc;
        logic pulse_en;
        logic [11:0] temp_cnt;
    } core_s;

    localparam cfg_s CFG_RESET = 24'h00_0001;
    localparam word_t CYCLE_RESET = 24'h00_0FA0;
    localparam word_t TSCALE_RESET = 24'h01_0000;

    localparam core_s CORE_DEFAULT = '{
        state: PS_RESET,
        cfg: CFG_RESET,
        cycle: CYCLE_RESET,
        tscale: TSCALE_RESET,
        pulse_en: 1'b1,
        default: '0
    };

endpackage

/* File: core/sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic out_r;
    logic out_nxt;

    // the output only moves once the second and third stages agree,
    // so a one-stage glitch never reaches the sequencer
    always_comb begin
        stage_nxt = {stage_r[1:0], din};
        out_nxt = (stage_r[1] == stage_r[2]) ? stage_r[1] : out_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage_r <= '0;
            out_r <= 1'b0;
        end else begin
            stage_r <= stage_nxt;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;

endmodule

`default_nettype wire

/* File: core/meter_supervision_events.sv */
`timescale 1ns/1ps
`default_nettype none

module meter_supervision_events (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supply_ok,
    input wire logic reset_pin_n,
    input wire meter_pkg::sample_s adc_sample,
    output logic sample_strobe,
    output logic energy_pulse_enable,
    output logic standby_mode,
    output logic sleep_mode,
    output logic irq_pin
);
    import meter_pkg::*;

    logic supply_ok_s;
    logic pin_ok_s;
    logic aw_rdy_r, aw_rdy_nxt, b_vld_r, b_vld_nxt;
    logic ar_rdy_r, ar_rdy_nxt, r_vld_r, r_vld_nxt;
    logic [1:0] b_resp_r, b_resp_nxt, r_resp_r, r_resp_nxt;
    logic [31:0] r_data_r, r_data_nxt;
    word_t rd_word;
    core_s core_r, core_nxt;
    logic [3:0] kdiv_last;
    logic divided_core_clk_tick, samp_tick, wr_en, cmd_ok;
    logic [7:0] cmd;
    logic [2:0] stat_set, stat_clr;
    word_t abs_v, abs_e, cnt1, low1;
    logic [39:0] acc1;
    logic signed [24:0] t_sum;
    logic signed [49:0] t_prod;
    logic [2:0] masked, masked_prev_r, masked_prev_nxt;
    logic [3:0] pulse_cnt_r, pulse_cnt_nxt;
    logic irq_r, irq_nxt;

    function automatic logic mapped(input logic [5:0] a);
        return (a[1:0] == 2'b00) && (a <= OFF_STATE);
    endfunction

    // byte-lane merge; lane 3 has no storage behind it
    function automatic word_t merge(input word_t old, input logic [31:0] d, input logic [3:0] be);
        word_t m;
        m = old;
        for (int i = 0; i < 3; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // supply monitor and reset pin arrive from outside the clock domain
    sync3 u_supply_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .din(supply_ok),
        .dout(supply_ok_s)
    );
    sync3 u_pin_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .din(reset_pin_n),
        .dout(pin_ok_s)
    );

    // write address and data are taken together, one beat per response
    assign wr_en = aw_rdy_r;

    always_comb begin
        unique case (s_axi_araddr)
            OFF_CONFIG: rd_word = core_r.cfg;
            OFF_STATUS: rd_word = {21'h0, core_r.status};
            OFF_MASK: rd_word = {21'h0, core_r.mask};
            OFF_CYCLE: rd_word = core_r.cycle;
            OFF_SAG_THR: rd_word = core_r.sag_thr;
            OFF_SAG_WIN: rd_word = core_r.sag_win;
            OFF_NL_INT: rd_word = core_r.nl_int;
            OFF_NL_MIN: rd_word = core_r.nl_min;
            OFF_TSCALE: rd_word = core_r.tscale;
            OFF_TEMP_ZERO_OFFSET: rd_word = core_r.temp_zero_offset;
            OFF_TEMP: rd_word = core_r.temp;
            OFF_STATE: rd_word = {19'h0, core_r.pulse_en, core_r.conv_run, core_r.state};
            default: rd_word = '0;
        endcase
    end

    // bus handshakes: ready is a one-cycle pulse, response held until taken
    always_comb begin
        aw_rdy_nxt = s_axi_awvalid && s_axi_wvalid && !aw_rdy_r && !b_vld_r;
        b_vld_nxt = aw_rdy_r || (b_vld_r && !s_axi_bready);
        b_resp_nxt = b_resp_r;
        if (aw_rdy_r) begin
            b_resp_nxt = mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
        end
        ar_rdy_nxt = s_axi_arvalid && !ar_rdy_r && !r_vld_r;
        r_vld_nxt = ar_rdy_r || (r_vld_r && !s_axi_rready);
        r_resp_nxt = r_resp_r;
        r_data_nxt = r_data_r;
        if (ar_rdy_r) begin
            r_resp_nxt = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            r_data_nxt = {8'h00, rd_word};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_r <= 1'b0;
            b_vld_r <= 1'b0;
            b_resp_r <= 2'b00;
            ar_rdy_r <= 1'b0;
            r_vld_r <= 1'b0;
            r_resp_r <= 2'b00;
            r_data_r <= '0;
        end else begin
            aw_rdy_r <= aw_rdy_nxt;
            b_vld_r <= b_vld_nxt;
            b_resp_r <= b_resp_nxt;
            ar_rdy_r <= ar_rdy_nxt;
            r_vld_r <= r_vld_nxt;
            r_resp_r <= r_resp_nxt;
            r_data_r <= r_data_nxt;
        end
    end

    // divisor zero behaves as one so the divided clock never stops
    assign kdiv_last = (core_r.cfg.divisor == 4'h0) ? 4'h0 : core_r.cfg.divisor - 4'h1;
    assign divided_core_clk_tick = (core_r.divided_core_clk_cnt == kdiv_last);
    assign samp_tick = divided_core_clk_tick && (core_r.samp_cnt == SAMPLE_DIV_LAST);
    assign cmd_ok = wr_en && (s_axi_awaddr == OFF_CMD) && s_axi_wstrb[0];
    assign cmd = s_axi_wdata[7:0];
    assign abs_v = adc_sample.volt[23] ? 24'(-adc_sample.volt) : adc_sample.volt;
    assign abs_e = adc_sample.energy[23] ? 24'(-adc_sample.energy) : adc_sample.energy;
    assign t_sum = $signed({adc_sample.temp_raw[23], adc_sample.temp_raw}) + $signed({core_r.temp_zero_offset[23], core_r.temp_zero_offset});
    assign t_prod = t_sum * $signed({1'b0, core_r.tscale});
    assign stat_clr = (wr_en && s_axi_awaddr == OFF_STATUS && s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'b000;

    // sequencer, register file and measurement supervision
    always_comb begin
        core_nxt = core_r;
        stat_set = '0;
        cnt1 = '0;
        low1 = '0;
        acc1 = '0;
        core_nxt.divided_core_clk_cnt = divided_core_clk_tick ? 4'h0 : core_r.divided_core_clk_cnt + 4'h1;
        core_nxt.samp_cnt = divided_core_clk_tick ? core_r.samp_cnt + 10'h001 : core_r.samp_cnt;
        core_nxt.samp_stb = samp_tick && core_r.conv_run;
        if (wr_en && core_r.state != PS_RESET) begin
            unique case (s_axi_awaddr)
                OFF_CONFIG: core_nxt.cfg = merge(core_r.cfg, s_axi_wdata, s_axi_wstrb);
                OFF_MASK: core_nxt.mask = s_axi_wstrb[0] ? s_axi_wdata[2:0] : core_r.mask;
                OFF_CYCLE: core_nxt.cycle = merge(core_r.cycle, s_axi_wdata, s_axi_wstrb);
                OFF_SAG_THR: core_nxt.sag_thr = merge(core_r.sag_thr, s_axi_wdata, s_axi_wstrb);
                OFF_SAG_WIN: core_nxt.sag_win = merge(core_r.sag_win, s_axi_wdata, s_axi_wstrb);
                OFF_NL_INT: core_nxt.nl_int = merge(core_r.nl_int, s_axi_wdata, s_axi_wstrb);
                OFF_NL_MIN: core_nxt.nl_min = merge(core_r.nl_min, s_axi_wdata, s_axi_wstrb);
                OFF_TSCALE: core_nxt.tscale = merge(core_r.tscale, s_axi_wdata, s_axi_wstrb);
                OFF_TEMP_ZERO_OFFSET: core_nxt.temp_zero_offset = merge(core_r.temp_zero_offset, s_axi_wdata, s_axi_wstrb);
                default: core_nxt.cfg = core_r.cfg;
            endcase
        end
        if (samp_tick && core_r.conv_run) begin
            // single conversions stop after the programmed cycle count
            core_nxt.conv_cnt = core_r.conv_cnt + 24'h00_0001;
            if (!core_r.conv_cont && core_nxt.conv_cnt >= core_r.cycle) begin
                core_nxt.conv_run = 1'b0;
            end
            // sag window: a zero threshold or window leaves detection idle
            if (core_r.sag_thr != '0 && core_r.sag_win != '0) begin
                cnt1 = core_r.sag_cnt + 24'h00_0001;
                low1 = core_r.sag_low + ((abs_v < core_r.sag_thr) ? 24'h00_0001 : 24'h00_0000);
                core_nxt.sag_cnt = cnt1;
                core_nxt.sag_low = low1;
                if (cnt1 >= core_r.sag_win) begin
                    stat_set[STAT_SAG] = ({low1, 1'b0} > {1'b0, core_r.sag_win});
                    core_nxt.sag_cnt = '0;
                    core_nxt.sag_low = '0;
                end
            end
            // no-load interval; accumulator saturates instead of wrapping
            if (core_r.nl_int == '0) begin
                core_nxt.pulse_en = 1'b1;
            end else begin
                cnt1 = core_r.nl_cnt + 24'h00_0001;
                acc1 = core_r.nl_acc + {16'h0000, abs_e};
                if (acc1 < core_r.nl_acc) begin
                    acc1 = '1;
                end
                core_nxt.nl_cnt = cnt1;
                core_nxt.nl_acc = acc1;
                if (cnt1 >= core_r.nl_int) begin
                    core_nxt.pulse_en = (acc1 >= {16'h0000, core_r.nl_min});
                    core_nxt.nl_cnt = '0;
                    core_nxt.nl_acc = '0;
                end
            end
            // temperature only in continuous mode with a usable cycle count
            if (core_r.conv_cont && core_r.cycle > 24'h00_0001) begin
                core_nxt.temp_cnt = core_r.temp_cnt + 12'h001;
                if (core_r.temp_cnt == TEMP_UPDATE_LAST) begin
                    core_nxt.temp_cnt = '0;
                    core_nxt.temp = t_prod[39:16];
                    stat_set[STAT_TEMP] = 1'b1;
                end
            end
        end
        unique case (core_r.state)
            PS_RESET: begin
                core_nxt = CORE_DEFAULT;
                core_nxt.state = PS_SETTLE;
            end
            PS_SETTLE: begin
                core_nxt.settle_cnt = core_r.settle_cnt + 4'h1;
                if (core_r.settle_cnt == SETTLE_LAST) begin
                    core_nxt.state = PS_ACTIVE;
                    stat_set[STAT_READY] = 1'b1;
                end
            end
            PS_ACTIVE: begin
                if (cmd_ok && (cmd == CMD_START_CONT || cmd == CMD_START_CONT_APF)) begin
                    core_nxt.conv_run = 1'b1;
                    core_nxt.conv_cont = 1'b1;
                    core_nxt.conv_cnt = '0;
                end else if (cmd_ok && cmd == CMD_START_SINGLE) begin
                    core_nxt.conv_run = 1'b1;
                    core_nxt.conv_cont = 1'b0;
                    core_nxt.conv_cnt = '0;
                end else if (cmd_ok && (cmd == CMD_POWER_UP || cmd == CMD_STANDBY || cmd == CMD_SLEEP)) begin
                    core_nxt.conv_run = 1'b0;
                    core_nxt.conv_cont = 1'b0;
                end
                if (cmd_ok && cmd == CMD_STANDBY) begin
                    core_nxt.state = PS_STANDBY;
                end else if (cmd_ok && cmd == CMD_SLEEP) begin
                    core_nxt.state = PS_SLEEP;
                end
            end
            PS_STANDBY: begin
                if (cmd_ok && cmd == CMD_POWER_UP) begin
                    core_nxt.state = PS_ACTIVE;
                    stat_set[STAT_READY] = 1'b1;
                end
            end
            PS_SLEEP: begin
                core_nxt.divided_core_clk_cnt = '0; // oscillator stopped
                core_nxt.samp_cnt = '0;
                if (cmd_ok && cmd == CMD_POWER_UP) begin
                    core_nxt.state = PS_RESET;
                end
            end
            default: core_nxt.state = PS_RESET;
        endcase
        if (core_r.state != PS_RESET) begin
            core_nxt.status = (core_r.status & ~stat_clr) | stat_set;
        end
        if (cmd_ok && cmd == CMD_SOFT_RESET) begin
            core_nxt.state = PS_RESET;
        end
        if (!supply_ok_s || !pin_ok_s) begin
            core_nxt = CORE_DEFAULT;
        end
        core_nxt.stby = (core_nxt.state == PS_STANDBY);
        core_nxt.slp = (core_nxt.state == PS_SLEEP);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_r <= CORE_DEFAULT;
        end else begin
            core_r <= core_nxt;
        end
    end

    // interrupt pin: level follows masked status, pulses mark new events
    assign masked = core_r.status & core_r.mask;
    always_comb begin
        masked_prev_nxt = masked;
        pulse_cnt_nxt = (pulse_cnt_r != 4'h0) ? pulse_cnt_r - 4'h1 : 4'h0;
        if (core_r.cfg.irq_pulse_select && (masked & ~masked_prev_r) != 3'b000) begin
            pulse_cnt_nxt = kdiv_last + 4'h1;
        end
        if (!core_r.cfg.irq_pulse_select) begin
            irq_nxt = core_r.cfg.irq_polarity_invert ? (masked != 3'b000) : (masked == 3'b000);
        end else begin
            irq_nxt = core_r.cfg.irq_polarity_invert ? (pulse_cnt_nxt != 4'h0) : (pulse_cnt_nxt == 4'h0);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            masked_prev_r <= '0;
            pulse_cnt_r <= '0;
            irq_r <= 1'b1;
        end else begin
            masked_prev_r <= masked_prev_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign s_axi_awready = aw_rdy_r;
    assign s_axi_wready = aw_rdy_r;
    assign s_axi_bvalid = b_vld_r;
    assign s_axi_bresp = b_resp_r;
    assign s_axi_arready = ar_rdy_r;
    assign s_axi_rvalid = r_vld_r;
    assign s_axi_rresp = r_resp_r;
    assign s_axi_rdata = r_data_r;
    assign sample_strobe = core_r.samp_stb;
    assign energy_pulse_enable = core_r.pulse_en;
    assign standby_mode = core_r.stby;
    assign sleep_mode = core_r.slp;
    assign irq_pin = irq_r;

endmodule

`default_nettype wire

/* File: verification/meter_supervision_events_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_supervision_events_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic sample_strobe,
    input wire logic energy_pulse_enable,
    input wire logic standby_mode,
    input wire logic sleep_mode,
    input wire logic irq_pin
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address and data are only ever taken together
    a_ready_pair: assert property (s_axi_awready |-> s_axi_wready) else $error("awready without wready");
    a_resp_follows: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write response");
    a_read_pulse: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid) else $error("read answer late");
    // defaults visible at the first edge after release
    a_irq_idle: assert property ($rose(aresetn) |-> irq_pin && energy_pulse_enable) else $error("reset idle");
    a_modes_reset: assert property ($rose(aresetn) |-> !standby_mode && !sleep_mode) else $error("mode reset");
    a_modes_excl: assert property (!(standby_mode && sleep_mode)) else $error("two power states");
    // samples are at least 1024 cycles apart, so a strobe is never followed by another soon
    a_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8]) else $error("strobe too close");
    a_down_quiet: assert property ((standby_mode || sleep_mode) && $past(standby_mode || sleep_mode, 2)
        |-> !sample_strobe) else $error("sampling while down");
endmodule
bind meter_supervision_events meter_supervision_events_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .sample_strobe(sample_strobe),
    .energy_pulse_enable(energy_pulse_enable), .standby_mode(standby_mode), .sleep_mode(sleep_mode),
    .irq_pin(irq_pin));
`default_nettype wire

/* File: verification/sample_source.sv */
`timescale 1ns/1ps
`default_nettype none
module sample_source (
    input wire logic aclk,
    input wire logic [23:0] volt_lvl,
    input wire logic [23:0] energy_lvl,
    output var meter_pkg::sample_s adc_sample
);
    import meter_pkg::*;
    logic sign_r = 1'b0;
    // sign flips every cycle: only the magnitude is steady, so absolute handling matters
    always_ff @(posedge aclk) begin
        sign_r <= ~sign_r;
    end
    assign adc_sample = '{volt: sign_r ? -volt_lvl : volt_lvl, energy: energy_lvl, temp_raw: 24'h00_0100};
endmodule
`default_nettype wire

/* File: verification/meter_supervision_events_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module meter_supervision_events_tb;
    import meter_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic reset_pin_n = 1'b1;
    logic supply_ok = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, strobe, pulse_en, stby, slp, irq;
    logic [1:0] bresp, rresp, rr, br;
    logic [31:0] rdata, rv;
    sample_s smp;
    int fails = 0, n_checks = 0, cyc = 0, low_cnt = 0, strb_cnt = 0;

    meter_supervision_events uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .supply_ok(supply_ok), .reset_pin_n(reset_pin_n), .adc_sample(smp), .sample_strobe(strobe),
        .energy_pulse_enable(pulse_en), .standby_mode(stby), .sleep_mode(slp), .irq_pin(irq));
    sample_source far (.aclk(aclk), .volt_lvl(24'h00_0010), .energy_lvl(24'h00_0010), .adc_sample(smp));

    always #10 aclk = ~aclk;
    // low cycles of the pin, read at the edge so pulses are never missed between calls
    always @(posedge aclk) begin
        if (irq === 1'b0) low_cnt++;
        cyc++;
        if (cyc == 30000) begin
            fails++;
            results();
        end
    end

    // strobes counted on the falling edge, clear of the edge that launches them
    always @(negedge aclk) begin
        if (strobe === 1'b1) strb_cnt++;
    end

    task automatic results();
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one write: valids held until the ready edge, bready stays high throughout
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        br = bresp;
    endtask
    task automatic rd(input logic [5:0] a);
        araddr <= a; arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rv = rdata; rr = rresp;
    endtask
    task automatic wait_active();
        repeat (40) begin
            rd(OFF_STATE);
            if (rv[2:0] === 3'h2) break;
        end
        chk("state", rv & 32'h0000_0007, 32'h0000_0002);
    endtask
    task automatic t_defaults();
        wait_active();
        rd(OFF_STATUS); chk("status", rv, 32'h0000_0001);
        rd(OFF_CONFIG); chk("config", rv, 32'h0000_0001);
        rd(OFF_CYCLE); chk("cycle", rv, 32'h0000_0FA0);
        rd(OFF_TSCALE); chk("tscale", rv, 32'h0001_0000);
        rd(6'h3C); chk("unmapped", {rr, rv[29:0]}, 32'h8000_0000);
        wr(6'h3C, 32'h0000_00FF); chk("bad write", br, 32'h0000_0002);
        chk("irq unmasked", irq, 1'b1);
    endtask
    task automatic t_irq_level();
        wr(OFF_MASK, 32'h0000_0001); chk("write ok", br, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        chk("irq low level", irq, 1'b0);
        wr(OFF_CONFIG, 32'h0000_0021); repeat (2) @(posedge aclk);
        chk("irq high level", irq, 1'b1);
        wr(OFF_STATUS, 32'h0000_0000); rd(OFF_STATUS);
        chk("status kept", rv, 32'h0000_0001);
        wr(OFF_STATUS, 32'h0000_0001); repeat (2) @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
    endtask
    // low pulse with divisor 2: exactly one pulse of two cycles on re-entering active
    task automatic t_pulse();
        wr(OFF_CONFIG, 32'h0000_0012);
        wr(OFF_CMD, {24'h00_0000, CMD_STANDBY}); repeat (2) @(posedge aclk);
        chk("standby", stby, 1'b1);
        low_cnt = 0;
        wr(OFF_CMD, {24'h00_0000, CMD_POWER_UP}); repeat (20) @(posedge aclk);
        chk("pulse cycles", low_cnt, 32'h0000_0002);
        chk("left standby", stby, 1'b0);
        rd(OFF_STATE); chk("quick active", rv & 32'h0000_0007, 32'h0000_0002);
    endtask
    task automatic t_sleep();
        wr(OFF_CMD, {24'h00_0000, CMD_SLEEP}); repeat (2) @(posedge aclk);
        chk("sleep", slp, 1'b1);
        wr(OFF_CMD, {24'h00_0000, CMD_POWER_UP});
        rd(OFF_STATE); chk("reinit", rv[2:0] == 3'h2, 1'b0);
        wait_active();
        chk("woke", slp, 1'b0);
    endtask
    task automatic t_resets();
        wr(OFF_CYCLE, 32'h0000_0123); wr(OFF_MASK, 32'h0000_0007);
        wr(OFF_CMD, {24'h00_0000, CMD_SOFT_RESET}); wait_active();
        rd(OFF_CYCLE); chk("soft cycle", rv, 32'h0000_0FA0);
        rd(OFF_MASK); chk("soft mask", rv, 32'h0000_0000);
        wr(OFF_CYCLE, 32'h0000_0123);
        reset_pin_n <= 1'b0; repeat (3) @(posedge aclk);
        reset_pin_n <= 1'b1; repeat (8) @(posedge aclk);
        wait_active();
        rd(OFF_CYCLE); chk("pin cycle", rv, 32'h0000_0FA0);
        // a supply dip restarts the whole sequence just like the pin
        wr(OFF_MASK, 32'h0000_0007);
        supply_ok <= 1'b0; repeat (3) @(posedge aclk);
        supply_ok <= 1'b1; repeat (8) @(posedge aclk);
        wait_active();
        rd(OFF_MASK); chk("supply mask", rv, 32'h0000_0000);
    endtask
    // small voltage of either sign against the threshold, tiny energy against the minimum
    task automatic t_sag_noload();
        wr(OFF_SAG_THR, 32'h0000_0100); wr(OFF_SAG_WIN, 32'h0000_0002);
        wr(OFF_NL_INT, 32'h0000_0002); wr(OFF_NL_MIN, 32'h0000_1000);
        wr(OFF_CYCLE, 32'h0000_0002);
        wr(OFF_STATUS, 32'h0000_0007);
        wr(OFF_CMD, {24'h00_0000, CMD_START_CONT}); strb_cnt = 0;
        repeat (8192) @(posedge aclk);
        chk("strobes", strb_cnt, 32'h0000_0008);
        rd(OFF_STATUS); chk("sag flag", rv & 32'h0000_0004, 32'h0000_0004);
        chk("no-load gate", pulse_en, 1'b0);
        chk("sag masked off", irq, 1'b1);
        wr(OFF_MASK, 32'h0000_0004); repeat (2) @(posedge aclk);
        chk("sag irq", irq, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults();
        t_irq_level();
        t_pulse();
        t_sleep();
        t_resets();
        t_sag_noload();
        results();
    end
endmodule
`default_nettype wire
